// *** common/biw_defs.vh ***
// constants and field layout of the bridge I/O window and secondary status block
//
// Notes on behaviour
// - latency byte at bits 31:24 of 0x18 reads zero, writes ignored.
// - capability nibbles 3:0 and 11:8 of 0x1c always read one.
// - bits 7:4 hold window base address bits 15:12, writable, reset zero.
// - window base address bits 11:0 are taken as zero.
// - bits 15:12 hold window limit address bits 15:12, writable, reset zero.
// - window limit address bits 11:0 are taken as all ones.
// - address bits 31:16 of base and limit come from separate upper registers.
// - programmed base and limit decide whether an I/O request is forwarded.
// - status bits 21, 23, 26:25 and reserved 20:16, 22 read zero.
// - bit 24 set on secondary-side parity error as requester; resets zero.
// - bit 24 never set while parity error response enable is clear.
// - bit 27 set when completing a request with completer abort; read only.
// - bit 28 set on receiving completer-abort completion; read only.
// - bit 29 set on receiving unsupported-request completion; read only.
// - bit 30 set on sending fatal or nonfatal error message while enabled.
// - bit 31 set whenever secondary side receives a poisoned packet.
`ifndef BIW_DEFS_VH
`define BIW_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define BIW_OFF_LATENCY     12'h018
`define BIW_OFF_IO_STATUS   12'h01c
`define BIW_OFF_CTRL        12'h040
`define BIW_OFF_INT_STATUS  12'h044
`define BIW_OFF_INT_MASK    12'h048

// ----------------------------------------------------------------------------
// field positions and fixed values
// ----------------------------------------------------------------------------
`define BIW_LATENCY_VAL     8'h00
`define BIW_IO_CAP_VAL      4'h1
`define BIW_NIB_RESET       4'h0
`define BIW_WIN_BASE_LOW    12'h000
`define BIW_WIN_LIMIT_LOW   12'hfff
`define BIW_STS_PERR        24
`define BIW_STS_SIG_CA      27
`define BIW_STS_RCV_CA      28
`define BIW_STS_RCV_UR      29
`define BIW_STS_SERR        30
`define BIW_STS_POISON      31

// ----------------------------------------------------------------------------
// event indices, shared by status, interrupt status and mask
// ----------------------------------------------------------------------------
`define BIW_EVT_NUM         6
`define BIW_EVT_PERR        0
`define BIW_EVT_SIG_CA      1
`define BIW_EVT_RCV_CA      2
`define BIW_EVT_RCV_UR      3
`define BIW_EVT_SERR        4
`define BIW_EVT_POISON      5
`define BIW_EVT_RESET       6'h00
`define BIW_EVT_W1C_MASK    6'h31

// ----------------------------------------------------------------------------
// control register
// ----------------------------------------------------------------------------
`define BIW_CTRL_PERR_EN    0
`define BIW_CTRL_SERR_EN    1
`define BIW_CTRL_RESET      2'h0

`endif

// *** hdl/biw_io_window_match.v ***
// inclusive range check of an I/O address against the forwarding window
`timescale 1ns/1ps
`default_nettype none
`include "biw_defs.vh"

module biw_io_window_match
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  base_nib,
  input  wire [3:0]  limit_nib,
  input  wire [15:0] base_upper,
  input  wire [15:0] limit_upper,
  input  wire        req_valid,
  input  wire [31:0] req_addr,
  output reg         fwd_valid_reg,
  output reg         fwd_hit_reg
);

  wire [31:0] win_base;
  wire [31:0] win_limit;
  wire        in_window;

  assign win_base  = {base_upper, base_nib, `BIW_WIN_BASE_LOW};
  assign win_limit = {limit_upper, limit_nib, `BIW_WIN_LIMIT_LOW};
  // base above limit gives an empty window, so nothing is forwarded
  assign in_window = (req_addr >= win_base) && (req_addr <= win_limit);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwd_valid_reg <= 1'b0;
      fwd_hit_reg   <= 1'b0;
    end
    else
    begin
      fwd_valid_reg <= req_valid;
      fwd_hit_reg   <= req_valid & in_window;
    end
  end

endmodule // biw_io_window_match
`default_nettype wire

// *** hdl/biw_top.v ***
// APB register bank for the bridge I/O window and secondary status flags
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "biw_defs.vh"

module biw_top
#(
  parameter ADDR_W = 12
)
(
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              evt_parity_error,
  input  wire              evt_abort_sent,
  input  wire              evt_abort_received,
  input  wire              evt_unsupported_received,
  input  wire              evt_error_msg_sent,
  input  wire              evt_poisoned_received,
  input  wire [15:0]       io_base_upper,
  input  wire [15:0]       io_limit_upper,
  input  wire              io_req_valid,
  input  wire [31:0]       io_req_addr,
  output wire              io_fwd_valid,
  output wire              io_fwd_hit,
  output reg               irq
);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function hit_off;
    input [ADDR_W-1:0] addr;
    input [11:0]       off;
    begin
      hit_off = (addr == off[ADDR_W-1:0]);
    end
  endfunction

  // event index to its bit inside the secondary status half-word
  function [31:0] place_status;
    input [`BIW_EVT_NUM-1:0] flags;
    begin
      place_status                  = 32'h0000_0000;
      place_status[`BIW_STS_PERR]   = flags[`BIW_EVT_PERR];
      place_status[`BIW_STS_SIG_CA] = flags[`BIW_EVT_SIG_CA];
      place_status[`BIW_STS_RCV_CA] = flags[`BIW_EVT_RCV_CA];
      place_status[`BIW_STS_RCV_UR] = flags[`BIW_EVT_RCV_UR];
      place_status[`BIW_STS_SERR]   = flags[`BIW_EVT_SERR];
      place_status[`BIW_STS_POISON] = flags[`BIW_EVT_POISON];
    end
  endfunction

  function [`BIW_EVT_NUM-1:0] pick_status;
    input [31:0] word;
    begin
      pick_status                 = `BIW_EVT_RESET;
      pick_status[`BIW_EVT_PERR]   = word[`BIW_STS_PERR];
      pick_status[`BIW_EVT_SIG_CA] = word[`BIW_STS_SIG_CA];
      pick_status[`BIW_EVT_RCV_CA] = word[`BIW_STS_RCV_CA];
      pick_status[`BIW_EVT_RCV_UR] = word[`BIW_STS_RCV_UR];
      pick_status[`BIW_EVT_SERR]   = word[`BIW_STS_SERR];
      pick_status[`BIW_EVT_POISON] = word[`BIW_STS_POISON];
    end
  endfunction

  // a register write lands only on a committed, accepted access to its lane
  function lane_write;
    input commit;
    input sel;
    input lane;
    begin
      lane_write = commit & sel & lane;
    end
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [3:0]              io_base_nib_reg;
  reg  [3:0]              io_base_nib_next;
  reg  [3:0]              io_limit_nib_reg;
  reg  [3:0]              io_limit_nib_next;
  reg  [1:0]              ctrl_reg;
  reg  [1:0]              ctrl_next;
  reg  [`BIW_EVT_NUM-1:0] sec_status_reg;
  reg  [`BIW_EVT_NUM-1:0] int_status_reg;
  reg  [`BIW_EVT_NUM-1:0] int_mask_reg;
  reg  [`BIW_EVT_NUM-1:0] int_mask_next;
  reg  [31:0]             rdata_next;
  reg                     slverr_next;

  wire                    setup_phase;
  wire                    wr_commit;
  wire                    sel_latency;
  wire                    sel_io_status;
  wire                    sel_ctrl;
  wire                    sel_int_status;
  wire                    sel_int_mask;
  wire                    mapped;
  wire [`BIW_EVT_NUM-1:0] evt_raw;
  wire [`BIW_EVT_NUM-1:0] evt_set;
  wire [`BIW_EVT_NUM-1:0] sts_clr;
  wire [`BIW_EVT_NUM-1:0] int_clr;
  wire [`BIW_EVT_NUM-1:0] wr_sts_ones;
  wire [`BIW_EVT_NUM-1:0] wr_int_ones;
  wire                    wr_base_nib;
  wire                    wr_limit_nib;
  wire                    wr_ctrl_lane;
  wire                    wr_mask_lane;
  wire                    wr_sts_lane;
  wire                    wr_int_lane;
  wire                    irq_pending;

  // --------------------------------------------------------------------------
  // apb handshake
  // --------------------------------------------------------------------------
  // answer is prepared in setup, so access completes with no wait state
  assign setup_phase    = psel & ~penable;
  assign wr_commit      = psel & penable & pready & pwrite & ~pslverr;

  assign sel_latency    = hit_off(paddr, `BIW_OFF_LATENCY);
  assign sel_io_status  = hit_off(paddr, `BIW_OFF_IO_STATUS);
  assign sel_ctrl       = hit_off(paddr, `BIW_OFF_CTRL);
  assign sel_int_status = hit_off(paddr, `BIW_OFF_INT_STATUS);
  assign sel_int_mask   = hit_off(paddr, `BIW_OFF_INT_MASK);
  assign mapped         = sel_latency | sel_io_status | sel_ctrl | sel_int_status | sel_int_mask;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (setup_phase)
    begin
      pready  <= 1'b1;
      pslverr <= slverr_next;
      prdata  <= rdata_next;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  always @*
  begin
    rdata_next  = 32'h0000_0000;
    slverr_next = ~mapped;
    if (pwrite)
    begin
      rdata_next = 32'h0000_0000;
    end
    else if (sel_latency)
    begin
      rdata_next[31:24] = `BIW_LATENCY_VAL;
    end
    else if (sel_io_status)
    begin
      // bits 20:16, 21, 22, 23, 26:25 stay zero from the default
      rdata_next        = place_status(sec_status_reg);
      rdata_next[3:0]   = `BIW_IO_CAP_VAL;
      rdata_next[7:4]   = io_base_nib_reg;
      rdata_next[11:8]  = `BIW_IO_CAP_VAL;
      rdata_next[15:12] = io_limit_nib_reg;
    end
    else if (sel_ctrl)
    begin
      rdata_next[1:0] = ctrl_reg;
    end
    else if (sel_int_status)
    begin
      rdata_next[`BIW_EVT_NUM-1:0] = int_status_reg;
    end
    else if (sel_int_mask)
    begin
      rdata_next[`BIW_EVT_NUM-1:0] = int_mask_reg;
    end
    else
    begin
      rdata_next = 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // write strobes
  // --------------------------------------------------------------------------
  // status clears ride on lane 3, nibbles on lanes 0 and 1, so byte writes stay apart
  assign wr_base_nib  = lane_write(wr_commit, sel_io_status, pstrb[0]);
  assign wr_limit_nib = lane_write(wr_commit, sel_io_status, pstrb[1]);
  assign wr_ctrl_lane = lane_write(wr_commit, sel_ctrl, pstrb[0]);
  assign wr_mask_lane = lane_write(wr_commit, sel_int_mask, pstrb[0]);
  assign wr_sts_lane  = lane_write(wr_commit, sel_io_status, pstrb[3]);
  assign wr_int_lane  = lane_write(wr_commit, sel_int_status, pstrb[0]);

  // --------------------------------------------------------------------------
  // window and control writes
  // --------------------------------------------------------------------------
  // latency byte and capability nibbles have no storage, writes fall away
  always @*
  begin
    io_base_nib_next  = io_base_nib_reg;
    io_limit_nib_next = io_limit_nib_reg;
    ctrl_next         = ctrl_reg;
    int_mask_next     = int_mask_reg;
    if (wr_base_nib)
    begin
      io_base_nib_next = pwdata[7:4];
    end
    if (wr_limit_nib)
    begin
      io_limit_nib_next = pwdata[15:12];
    end
    if (wr_ctrl_lane)
    begin
      ctrl_next = pwdata[1:0];
    end
    if (wr_mask_lane)
    begin
      int_mask_next = pwdata[`BIW_EVT_NUM-1:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_base_nib_reg  <= `BIW_NIB_RESET;
      io_limit_nib_reg <= `BIW_NIB_RESET;
      ctrl_reg         <= `BIW_CTRL_RESET;
      int_mask_reg     <= `BIW_EVT_RESET;
    end
    else
    begin
      io_base_nib_reg  <= io_base_nib_next;
      io_limit_nib_reg <= io_limit_nib_next;
      ctrl_reg         <= ctrl_next;
      int_mask_reg     <= int_mask_next;
    end
  end

  // --------------------------------------------------------------------------
  // event capture
  // --------------------------------------------------------------------------
  assign evt_raw[`BIW_EVT_PERR]   = evt_parity_error;
  assign evt_raw[`BIW_EVT_SIG_CA] = evt_abort_sent;
  assign evt_raw[`BIW_EVT_RCV_CA] = evt_abort_received;
  assign evt_raw[`BIW_EVT_RCV_UR] = evt_unsupported_received;
  assign evt_raw[`BIW_EVT_SERR]   = evt_error_msg_sent;
  assign evt_raw[`BIW_EVT_POISON] = evt_poisoned_received;

  // reporting enables gate the event itself, so a later enable sets nothing
  assign evt_set[`BIW_EVT_PERR]   = evt_raw[`BIW_EVT_PERR] & ctrl_reg[`BIW_CTRL_PERR_EN];
  assign evt_set[`BIW_EVT_SIG_CA] = evt_raw[`BIW_EVT_SIG_CA];
  assign evt_set[`BIW_EVT_RCV_CA] = evt_raw[`BIW_EVT_RCV_CA];
  assign evt_set[`BIW_EVT_RCV_UR] = evt_raw[`BIW_EVT_RCV_UR];
  assign evt_set[`BIW_EVT_SERR]   = evt_raw[`BIW_EVT_SERR] & ctrl_reg[`BIW_CTRL_SERR_EN];
  assign evt_set[`BIW_EVT_POISON] = evt_raw[`BIW_EVT_POISON];

  // only bits 24, 30, 31 take write-one-to-clear; 27..29 ignore writes
  assign wr_sts_ones = pick_status(pwdata) & {`BIW_EVT_NUM{pstrb[3]}};
  assign sts_clr     = wr_sts_lane ? (wr_sts_ones & `BIW_EVT_W1C_MASK) : `BIW_EVT_RESET;
  assign wr_int_ones = pwdata[`BIW_EVT_NUM-1:0] & {`BIW_EVT_NUM{pstrb[0]}};
  assign int_clr     = wr_int_lane ? wr_int_ones : `BIW_EVT_RESET;

  // --------------------------------------------------------------------------
  // sticky flags
  // --------------------------------------------------------------------------
  // a set in the clearing cycle wins, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < `BIW_EVT_NUM; gi = gi + 1)
    begin : g_flag
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sec_status_reg[gi] <= 1'b0;
          int_status_reg[gi] <= 1'b0;
        end
        else
        begin
          sec_status_reg[gi] <= evt_set[gi] | (sec_status_reg[gi] & ~sts_clr[gi]);
          int_status_reg[gi] <= evt_set[gi] | (int_status_reg[gi] & ~int_clr[gi]);
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // interrupt
  // --------------------------------------------------------------------------
  // any unmasked flag asks for service
  assign irq_pending = |(int_status_reg & int_mask_reg);

  // follows the flop one cycle late; eases timing at the cost of a cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_pending;
    end
  end

  // --------------------------------------------------------------------------
  // forwarding decision
  // --------------------------------------------------------------------------
  biw_io_window_match u_match
  (
    .clk           (pclk),
    .rst_n         (presetn),
    .base_nib      (io_base_nib_reg),
    .limit_nib     (io_limit_nib_reg),
    .base_upper    (io_base_upper),
    .limit_upper   (io_limit_upper),
    .req_valid     (io_req_valid),
    .req_addr      (io_req_addr),
    .fwd_valid_reg (io_fwd_valid),
    .fwd_hit_reg   (io_fwd_hit)
  );

endmodule // biw_top
`default_nettype wire

// *** testbench/biw_top_asserts.sv ***
// port checker for the bridge I/O window register bank
`timescale 1ns/1ps
`default_nettype none
`include "biw_defs.vh"
module biw_top_asserts
#(
  parameter ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [15:0]       io_base_upper,
  input wire logic [15:0]       io_limit_upper,
  input wire logic              io_req_valid,
  input wire logic [31:0]       io_req_addr,
  input wire logic              io_fwd_valid,
  input wire logic              io_fwd_hit,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = paddr inside {`BIW_OFF_LATENCY, `BIW_OFF_IO_STATUS, `BIW_OFF_CTRL,
                                    `BIW_OFF_INT_STATUS, `BIW_OFF_INT_MASK};
  wire logic rd_done = pready && !pwrite;
  wire logic [15:0] up = io_req_addr[31:16];
  // --------------------------------------------------------------------------
  // bus answer
  // --------------------------------------------------------------------------
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready in the cycle after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_err_unmapped: assert property (psel && !penable && !mapped |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside the answer cycle");
  // --------------------------------------------------------------------------
  // fixed fields
  // --------------------------------------------------------------------------
  a_latency_zero: assert property (rd_done && paddr == `BIW_OFF_LATENCY |-> prdata == 32'h0)
    else $error("latency word not zero");
  a_fixed_fields: assert property (rd_done && paddr == `BIW_OFF_IO_STATUS |->
    prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1 && prdata[23:16] == 8'h0 && prdata[26:25] == 2'b0)
    else $error("fixed field of window word wrong");
  // --------------------------------------------------------------------------
  // forwarding decision
  // --------------------------------------------------------------------------
  a_fwd_follow: assert property (io_req_valid |=> io_fwd_valid)
    else $error("forward decision missing");
  a_fwd_idle: assert property (!io_req_valid |=> !io_fwd_valid && !io_fwd_hit)
    else $error("forward decision without request");
  a_fwd_outside: assert property (io_req_valid && (up < io_base_upper || up > io_limit_upper) |=> !io_fwd_hit)
    else $error("hit outside upper address range");
  a_fwd_inside: assert property (io_req_valid && up > io_base_upper && up < io_limit_upper |=> io_fwd_hit)
    else $error("miss inside upper address range");
  c_refused: cover property (pready && pslverr);
  c_hit: cover property (io_fwd_hit);
  c_irq: cover property (irq);
endmodule // biw_top_asserts
bind biw_top biw_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_base_upper(io_base_upper), .io_limit_upper(io_limit_upper), .io_req_valid(io_req_valid),
  .io_req_addr(io_req_addr), .io_fwd_valid(io_fwd_valid), .io_fwd_hit(io_fwd_hit), .irq(irq));
`default_nettype wire

// *** testbench/biw_evt_src.sv ***
// secondary-side transaction logic model that raises event pulses
`timescale 1ns/1ps
`default_nettype none
module biw_evt_src
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] fire,
  input  wire logic       slow,
  output var  logic [5:0] evt
);
  logic [5:0] dly1_reg;
  logic [5:0] dly2_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dly1_reg <= 6'h00;
      dly2_reg <= 6'h00;
      evt <= 6'h00;
    end
    else
    begin
      dly1_reg <= fire;
      dly2_reg <= dly1_reg;
      // slow path stands for a completion that arrives late
      evt <= slow ? dly2_reg : fire;
    end
  end
endmodule // biw_evt_src
`default_nettype wire

// *** testbench/biw_top_tb.sv ***
// self-checking bench for biw_top against a behavioural register model
`timescale 1ns/1ps
`default_nettype none
module biw_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, slow;
  logic io_req_valid, io_fwd_valid, io_fwd_hit, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, io_req_addr, rd;
  logic [3:0] pstrb, bn, ln;
  logic [15:0] io_base_upper, io_limit_upper, u;
  logic [5:0] fire, evt, sec, ist, msk;
  logic [1:0] ctl;
  int seed, cyc, num_errors, num_checks;
  biw_top #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_parity_error(evt[0]), .evt_abort_sent(evt[1]), .evt_abort_received(evt[2]),
    .evt_unsupported_received(evt[3]), .evt_error_msg_sent(evt[4]), .evt_poisoned_received(evt[5]),
    .io_base_upper(io_base_upper), .io_limit_upper(io_limit_upper), .io_req_valid(io_req_valid),
    .io_req_addr(io_req_addr), .io_fwd_valid(io_fwd_valid), .io_fwd_hit(io_fwd_hit), .irq(irq));
  biw_evt_src src (.pclk(pclk), .presetn(presetn), .fire(fire), .slow(slow), .evt(evt));
  always #12.5 pclk = ~pclk;
  // --------------------------------------------------------------------------
  // model, reporting and bus tasks
  // --------------------------------------------------------------------------
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    // events never coincide with writes, so set-over-clear is not modelled
    if (|evt)
    begin
      sec = sec | (evt & {1'b1, ctl[1], 3'h7, ctl[0]});
      ist = ist | (evt & {1'b1, ctl[1], 3'h7, ctl[0]});
    end
    if (cyc == 5000)
    begin
      num_errors++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  function logic [31:0] model_rd(input logic [11:0] a);
    case (a)
      12'h01c: model_rd = {sec[5:1], 2'b00, sec[0], 8'h00, ln, 4'h1, bn, 4'h1};
      12'h040: model_rd = {30'h0, ctl};
      12'h044: model_rd = {26'h0, ist};
      12'h048: model_rd = {26'h0, msk};
      default: model_rd = 32'h0;
    endcase
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count here: only the bench timeout ends a hung access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_bit("pslverr", !(a inside {12'h018, 12'h01c, 12'h040, 12'h044, 12'h048}), er);
    if (!w)
      chk("prdata", model_rd(a), rd);
    else if (!er)
      case (a)
        12'h01c:
        begin
          if (s[0]) bn = d[7:4];
          if (s[1]) ln = d[15:12];
          if (s[3]) sec = sec & ~{d[31:30], 3'h0, d[24]};
        end
        12'h040: if (s[0]) ctl = d[1:0];
        12'h044: if (s[0]) ist = ist & ~d[5:0];
        12'h048: if (s[0]) msk = d[5:0];
        default: ;
      endcase
    @(posedge pclk);
  endtask
  task win(input logic [31:0] a);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = {io_base_upper, bn, 12'h000};
    hi = {io_limit_upper, ln, 12'hfff};
    io_req_addr <= a;
    io_req_valid <= 1'b1;
    @(posedge pclk);
    io_req_valid <= 1'b0;
    @(posedge pclk);
    chk_bit("io_fwd_valid", 1'b1, io_fwd_valid);
    chk_bit("io_fwd_hit", a >= lo && a <= hi, io_fwd_hit);
  endtask
  task ev(input int i);
    fire <= 6'h01 << i;
    @(posedge pclk);
    fire <= 6'h00;
    repeat (6) @(posedge pclk);
  endtask
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    seed = 32'h933341e9;
    {cyc, num_errors, num_checks} = '0;
    {pclk, psel, penable, pwrite, paddr, pwdata, pstrb, slow, fire} = '0;
    {io_req_valid, io_req_addr, io_base_upper, io_limit_upper} = '0;
    {bn, ln, ctl, sec, ist, msk} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h018, 0, 4'hf);
    apb(0, 12'h01c, 0, 4'hf);
    apb(1, 12'h018, $random(seed), 4'hf);
    apb(0, 12'h018, 0, 4'hf);
    apb(1, 12'h01c, 32'hffff_ffff, 4'h2);
    apb(0, 12'h01c, 0, 4'hf);
    apb(1, 12'h01c, 32'h00ff_ffff, 4'hf);
    apb(0, 12'h01c, 0, 4'hf);
    apb(1, 12'h020, 32'h1, 4'hf);
    apb(0, 12'h04c, 0, 4'hf);
    for (int k = 0; k < 12; k++)
    begin
      u = $random(seed);
      io_base_upper <= u;
      io_limit_upper <= u + 16'(k % 3);
      apb(1, 12'h01c, $random(seed), 4'h3);
      win({u, bn, 12'h000});
      win({u, bn, 12'h000} - 1);
      win({u + 16'(k % 3), ln, 12'hfff});
      win({u + 16'(k % 3), ln, 12'hfff} + 1);
      win({u + 16'h1, 16'($random(seed))});
    end
    for (int c = 0; c < 4; c += 3)
    begin
      apb(1, 12'h040, c, 4'hf);
      apb(1, 12'h048, $random(seed), 4'hf);
      for (int i = 0; i < 6; i++)
      begin
        slow <= $random(seed);
        ev(i);
        apb(0, 12'h01c, 0, 4'hf);
        apb(0, 12'h044, 0, 4'hf);
        chk_bit("irq", |(ist & msk), irq);
      end
      apb(1, 12'h01c, 32'h0, 4'h8);
      apb(0, 12'h01c, 0, 4'hf);
      apb(1, 12'h01c, 32'hff00_0000, 4'h8);
      apb(0, 12'h01c, 0, 4'hf);
      apb(1, 12'h044, 32'h3f, 4'hf);
      apb(0, 12'h044, 0, 4'hf);
      chk_bit("irq", 1'b0, irq);
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    {bn, ln, ctl, sec, ist, msk} = '0;
    apb(0, 12'h01c, 0, 4'hf);
    apb(0, 12'h040, 0, 4'hf);
    apb(0, 12'h048, 0, 4'hf);
    chk_bit("irq", 1'b0, irq);
    summarize();
  end
endmodule // biw_top_tb
`default_nettype wire
